// File: rtl/gpp_map.vh
`ifndef GPP_MAP_VH
`define GPP_MAP_VH
// register byte offsets
`define GPP_OFF_A_DATA    12'h000
`define GPP_OFF_A_DIR     12'h004
`define GPP_OFF_E_DATA    12'h008
`define GPP_OFF_E_DIR     12'h00c
`define GPP_OFF_ANSEL     12'h010
`define GPP_OFF_PERIPH    12'h014
// widths
`define GPP_A_W           6
`define GPP_E_W           3
// field positions
`define GPP_PSP_BIT       4
`define GPP_OD_BIT        4
// reset values
`define GPP_A_DIR_RST     6'h3f
`define GPP_E_DIR_RST     8'h07
`define GPP_ANSEL_RST     4'h0
`define GPP_LAT_RST       6'h00
// analog select codes: 0 all analog but port a pin 4, 1 only port a low analog, else digital
`define GPP_ANSEL_ALL     4'h0
`define GPP_ANSEL_ALOW    4'h1
`endif

// File: rtl/gpp_pin_cell.v
`timescale 1ns/1ps
// one general purpose pin: direction, latch, peripheral override, analog gating
module gpp_pin_cell (
  input  wire dir_i,
  input  wire latch_i,
  input  wire od_i,
  input  wire periph_en_i,
  input  wire periph_out_i,
  input  wire periph_oe_i,
  input  wire analog_i,
  input  wire pin_i,
  output wire drive_o,
  output wire oe_o,
  output wire read_o
);
  wire gp_oe;
  wire val;
  assign gp_oe = ~dir_i;
  assign val = periph_en_i ? periph_out_i : latch_i;
  assign drive_o = od_i ? 1'b0 : val;
  assign oe_o = periph_en_i ? (periph_oe_i & ~(od_i & val)) : (gp_oe & ~(od_i & val));
  assign read_o = analog_i ? 1'b0 : pin_i;
endmodule

// File: rtl/gpp_top.v
`timescale 1ns/1ps
`include "gpp_map.vh"
// Functional notes
// - six pin bidirectional port, per-pin direction
// - direction one releases the driver
// - direction zero drives output latch
// - data read gives pins, write latch
// - port writes load the written data, no pin merge
// - timer clock pin is open drain
// - enabled peripheral takes over its pin
// - analog select register picks analog pins
// - reset makes analog pins, reading zero
// - three pin port with own directions
// - enable bit four makes slave controls
// - analog three pin reads zero
module gpp_top (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        ce_i,
  input  wire        hsel_i,
  input  wire [11:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire [5:0]  a_pin_i,
  output reg  [5:0]  a_pin_o,
  output reg  [5:0]  a_pin_oe_o,
  input  wire [2:0]  e_pin_i,
  output reg  [2:0]  e_pin_o,
  output reg  [2:0]  e_pin_oe_o,
  input  wire [5:0]  a_periph_out_i,
  input  wire [5:0]  a_periph_oe_i,
  output reg         timer_zero_clock_o,
  output reg         psp_rd_o,
  output reg         psp_wr_o,
  output reg         psp_cs_o,
  output reg         psp_mode_o
);
  reg  [5:0]  a_lat_reg;
  reg  [5:0]  a_dir_reg;
  reg  [2:0]  e_lat_reg;
  reg  [7:0]  e_dir_reg;
  reg  [3:0]  ansel_reg;
  reg  [5:0]  periph_en_reg;
  reg         wr_pend_reg;
  reg  [11:0] addr_reg;
  wire        a_phase;
  wire [5:0]  a_analog;
  wire [2:0]  e_analog;
  wire [5:0]  a_drv;
  wire [5:0]  a_oe;
  wire [5:0]  a_rd;
  wire [2:0]  e_drv;
  wire [2:0]  e_oe;
  wire [2:0]  e_rd;
  wire        psp_en;
  wire [5:0]  a_od_mask;
  wire [5:0]  a_rmw;
  wire [5:0]  e_rmw;
  reg  [31:0] rdata_next;

  // read-modify-write merge: the pin term is masked by 6'h00, so the written data passes unchanged
  function [5:0] rmw_merge;
    input [5:0] pins;
    input [5:0] dir;
    input [5:0] wdat;
    begin
      rmw_merge = wdat | (pins & 6'h00 & dir);
    end
  endfunction

  // analog map: pins 0..3,5 analog-capable on port a, all on port e
  // analog select decode
  assign a_analog = (ansel_reg == `GPP_ANSEL_ALL)  ? 6'h2f :
                    (ansel_reg == `GPP_ANSEL_ALOW) ? 6'h0f : 6'h00;
  assign e_analog = (ansel_reg == `GPP_ANSEL_ALL) ? 3'h7 : 3'h0;
  assign a_od_mask = 6'h10;
  assign psp_en = e_dir_reg[`GPP_PSP_BIT];
  assign a_phase = hsel_i & hready_i & htrans_i[1];

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_a
      gpp_pin_cell u_cell (
        .dir_i        (a_dir_reg[gi]),
        .latch_i      (a_lat_reg[gi]),
        .od_i         (a_od_mask[gi]),
        .periph_en_i  (periph_en_reg[gi]),
        .periph_out_i (a_periph_out_i[gi]),
        .periph_oe_i  (a_periph_oe_i[gi]),
        .analog_i     (a_analog[gi]),
        .pin_i        (a_pin_i[gi]),
        .drive_o      (a_drv[gi]),
        .oe_o         (a_oe[gi]),
        .read_o       (a_rd[gi])
      );
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_e
      gpp_pin_cell u_cell (
        .dir_i        (e_dir_reg[gi] | psp_en),
        .latch_i      (e_lat_reg[gi]),
        .od_i         (1'b0),
        .periph_en_i  (1'b0),
        .periph_out_i (1'b0),
        .periph_oe_i  (1'b0),
        .analog_i     (e_analog[gi]),
        .pin_i        (e_pin_i[gi]),
        .drive_o      (e_drv[gi]),
        .oe_o         (e_oe[gi]),
        .read_o       (e_rd[gi])
      );
    end
  endgenerate

  assign a_rmw = rmw_merge(a_rd, a_dir_reg, hwdata_i[5:0]);
  assign e_rmw = rmw_merge({3'h0, e_rd}, 6'h00, {3'h0, hwdata_i[2:0]}) ;

  // read mux on address phase
  always @* begin
    rdata_next = 32'h0000_0000;
    if (haddr_i == `GPP_OFF_A_DATA) begin
      rdata_next = {26'h0, a_rd};
    end else if (haddr_i == `GPP_OFF_A_DIR) begin
      rdata_next = {26'h0, a_dir_reg};
    end else if (haddr_i == `GPP_OFF_E_DATA) begin
      rdata_next = {29'h0, e_rd};
    end else if (haddr_i == `GPP_OFF_E_DIR) begin
      rdata_next = {24'h0, e_dir_reg};
    end else if (haddr_i == `GPP_OFF_ANSEL) begin
      rdata_next = {28'h0, ansel_reg};
    end else if (haddr_i == `GPP_OFF_PERIPH) begin
      rdata_next = {26'h0, periph_en_reg};
    end
  end

  // bus slave and register file
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      a_lat_reg     <= `GPP_LAT_RST;
      a_dir_reg     <= `GPP_A_DIR_RST;
      e_lat_reg     <= 3'h0;
      e_dir_reg     <= `GPP_E_DIR_RST;
      ansel_reg     <= `GPP_ANSEL_RST;
      periph_en_reg <= 6'h00;
      wr_pend_reg   <= 1'b0;
      addr_reg      <= 12'h000;
      hrdata_o      <= 32'h0000_0000;
      hreadyout_o   <= 1'b1;
      hresp_o       <= 1'b0;
    end else if (ce_i) begin
      wr_pend_reg <= a_phase & hwrite_i;
      if (a_phase) begin
        addr_reg <= haddr_i;
      end
      if (a_phase & ~hwrite_i) begin
        hrdata_o <= rdata_next;
      end
      if (wr_pend_reg) begin
        if (addr_reg == `GPP_OFF_A_DATA) begin
          a_lat_reg <= a_rmw;
        end else if (addr_reg == `GPP_OFF_A_DIR) begin
          a_dir_reg <= hwdata_i[5:0];
        end else if (addr_reg == `GPP_OFF_E_DATA) begin
          e_lat_reg <= e_rmw[2:0];
        end else if (addr_reg == `GPP_OFF_E_DIR) begin
          e_dir_reg <= {3'h0, hwdata_i[4:0]};
        end else if (addr_reg == `GPP_OFF_ANSEL) begin
          ansel_reg <= hwdata_i[3:0];
        end else if (addr_reg == `GPP_OFF_PERIPH) begin
          periph_en_reg <= hwdata_i[5:0];
        end
      end
    end
  end

  // registered pin and control outputs
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      a_pin_o            <= 6'h00;
      a_pin_oe_o         <= 6'h00;
      e_pin_o            <= 3'h0;
      e_pin_oe_o         <= 3'h0;
      timer_zero_clock_o <= 1'b0;
      psp_rd_o           <= 1'b0;
      psp_wr_o           <= 1'b0;
      psp_cs_o           <= 1'b0;
      psp_mode_o         <= 1'b0;
    end else if (ce_i) begin
      a_pin_o            <= a_drv;
      a_pin_oe_o         <= a_oe;
      e_pin_o            <= e_drv;
      e_pin_oe_o         <= e_oe;
      timer_zero_clock_o <= a_pin_i[`GPP_OD_BIT];
      psp_mode_o         <= psp_en;
      psp_rd_o           <= psp_en & e_pin_i[0];
      psp_wr_o           <= psp_en & e_pin_i[1];
      psp_cs_o           <= psp_en & e_pin_i[2];
    end
  end
endmodule

// File: verif/gpp_checker.sv
`timescale 1ns/1ps
// watches bus answers, pin drivers and slave controls
module gpp_checker (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        hsel_i,
  input wire [11:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire [5:0]  a_pin_i,
  input wire [5:0]  a_pin_o,
  input wire [5:0]  a_pin_oe_o,
  input wire [2:0]  e_pin_oe_o,
  input wire        timer_zero_clock_o,
  input wire        psp_rd_o,
  input wire        psp_wr_o,
  input wire        psp_cs_o,
  input wire        psp_mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // bus answers and reset state
  a_resp_okay:
    assert property (hresp_o == 1'b0) else $error("resp");
  a_ready_high:
    assert property (hreadyout_o) else $error("ready");
  a_unmap_zero:
    assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i >= 12'h018 |=> hrdata_o == 32'h0)
      else $error("unmapped");
  a_reset_quiet:
    assert property ($fell(reset_i) |-> a_pin_oe_o == 6'h0 && e_pin_oe_o == 3'h0 && hrdata_o == 32'h0)
      else $error("reset");
  // open drain pin and timer clock
  a_od_low:
    assert property (a_pin_o[4] == 1'b0) else $error("open drain");
  a_tmr_follow:
    assert property (!reset_i |=> timer_zero_clock_o == $past(a_pin_i[4])) else $error("timer clock");
  // slave port controls
  a_psp_idle:
    assert property (!psp_mode_o && !$past(psp_mode_o) |-> {psp_cs_o, psp_wr_o, psp_rd_o} == 3'h0)
      else $error("slave idle");
  a_psp_input:
    assert property (psp_mode_o |-> e_pin_oe_o == 3'h0) else $error("slave input");
  cover property (psp_mode_o);
  cover property (a_pin_oe_o[4]);
  cover property (hsel_i && htrans_i[1] && hwrite_i);
endmodule
bind gpp_top gpp_checker i_chk (.clk_sys_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .a_pin_i, .a_pin_o, .a_pin_oe_o, .e_pin_oe_o, .timer_zero_clock_o,
  .psp_rd_o, .psp_wr_o, .psp_cs_o, .psp_mode_o);

// File: verif/gpp_pin_env.sv
`timescale 1ns/1ps
// outside circuits: a released pin shows the outside level
module gpp_pin_env (
  input  wire [5:0] a_o_i,
  input  wire [5:0] a_oe_i,
  input  wire [5:0] a_ext_i,
  input  wire [2:0] e_o_i,
  input  wire [2:0] e_oe_i,
  input  wire [2:0] e_ext_i,
  output wire [5:0] a_o,
  output wire [2:0] e_o
);
  // wire level from driver enable
  assign a_o = (a_oe_i & a_o_i) | (~a_oe_i & a_ext_i);
  assign e_o = (e_oe_i & e_o_i) | (~e_oe_i & e_ext_i);
endmodule

// File: verif/tb_bidir_gpio_ports_with_psp_control.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_bidir_gpio_ports_with_psp_control;
  reg         clk_sys_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [11:0] haddr_i = 12'h0;
  reg  [1:0]  htrans_i = 2'h0;
  reg         hwrite_i = 1'b0;
  reg  [31:0] hwdata_i = 32'h0;
  reg  [5:0]  a_periph_out_i = 6'h0;
  reg  [5:0]  a_periph_oe_i = 6'h0;
  reg  [5:0]  ext_a = 6'h3f;
  reg  [2:0]  ext_e = 3'h7;
  reg  [31:0] rd;
  integer     error_cnt = 0;
  integer     tests_run = 0;
  wire [31:0] hrdata_o;
  wire [5:0]  a_pin_i, a_pin_o, a_pin_oe_o;
  wire [2:0]  e_pin_i, e_pin_o, e_pin_oe_o;
  wire        hreadyout_o, hresp_o, timer_zero_clock_o, psp_rd_o, psp_wr_o, psp_cs_o, psp_mode_o;
  // design, always enabled and selected
  gpp_top i_dut (.clk_sys_i, .reset_i, .ce_i(1'b1), .hsel_i(1'b1), .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .a_pin_i,
    .a_pin_o, .a_pin_oe_o, .e_pin_i, .e_pin_o, .e_pin_oe_o, .a_periph_out_i, .a_periph_oe_i,
    .timer_zero_clock_o, .psp_rd_o, .psp_wr_o, .psp_cs_o, .psp_mode_o);
  gpp_pin_env i_env (.a_o_i(a_pin_o), .a_oe_i(a_pin_oe_o), .a_ext_i(ext_a), .e_o_i(e_pin_o),
    .e_oe_i(e_pin_oe_o), .e_ext_i(ext_e), .a_o(a_pin_i), .e_o(e_pin_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // wait for hready, sampled at the falling edge before each rising edge
  task hs;
    integer n;
    reg     s;
    begin
      n = 0;
      s = 1'b0;
      while (!s) begin
        @(negedge clk_sys_i);
        s = (hreadyout_o === 1'b1);
        rd = hrdata_o;
        @(posedge clk_sys_i);
        n = n + 1;
        if (n > 50) begin
          error_cnt++;
          final_report;
        end
      end
    end
  endtask
  // one single word transfer, read data left in rd
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_i);
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      hs;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      hs;
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      `CHK("read", e, rd)
    end
  endtask
  task st;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task t_reset;
    begin
      rc(12'h004, 32'h3f);
      rc(12'h00c, 32'h07);
      rc(12'h010, 32'h0);
      rc(12'h000, 32'h10);
      rc(12'h008, 32'h0);
      rc(12'h020, 32'h0);
      `CHK("a_oe", 6'h0, a_pin_oe_o)
      `CHK("resp", 1'b0, hresp_o)
      $display("reset test ended");
    end
  endtask
  task t_out;
    begin
      bus(1'b1, 12'h010, 32'h7);
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b1, 12'h004, 32'h0);
      bus(1'b1, 12'h000, 32'h2a);
      st;
      `CHK("a_oe", 6'h3f, a_pin_oe_o)
      `CHK("a_out", 6'h2a, a_pin_o)
      rc(12'h000, 32'h2a);
      bus(1'b1, 12'h000, 32'h3f);
      st;
      `CHK("a_oe", 6'h2f, a_pin_oe_o)
      rc(12'h000, 32'h3f);
      @(posedge clk_sys_i);
      ext_a <= 6'h0;
      bus(1'b1, 12'h004, 32'h30);
      rc(12'h000, 32'h0f);
      `CHK("a_oe", 6'h0f, a_pin_oe_o)
      `CHK("tmr", 1'b0, timer_zero_clock_o)
      bus(1'b1, 12'h004, 32'h3f);
      a_periph_out_i <= 6'h01;
      a_periph_oe_i <= 6'h01;
      bus(1'b1, 12'h014, 32'h1);
      st;
      `CHK("periph", 7'h41, {a_pin_o[0], a_pin_oe_o})
      bus(1'b1, 12'h014, 32'h0);
      ext_a <= 6'h3f;
      bus(1'b1, 12'h010, 32'h1);
      rc(12'h000, 32'h30);
      $display("six pin test ended");
    end
  endtask
  task t_e;
    begin
      bus(1'b1, 12'h010, 32'h7);
      bus(1'b1, 12'h00c, 32'h2);
      bus(1'b1, 12'h008, 32'h5);
      st;
      `CHK("e_pins", 6'h2d, {e_pin_o, e_pin_oe_o})
      bus(1'b1, 12'h00c, 32'h17);
      ext_e <= 3'h5;
      st;
      `CHK("slave", 7'h68, {psp_mode_o, psp_cs_o, psp_wr_o, psp_rd_o, e_pin_oe_o})
      bus(1'b1, 12'h00c, 32'h7);
      bus(1'b1, 12'h010, 32'h0);
      rc(12'h008, 32'h0);
      $display("three pin test ended");
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // reset, then the scenarios
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset;
    t_out;
    t_e;
    final_report;
  end
endmodule
